// ==== logic/nvm_pkg.sv ====
// Shared constants and types for the data flash controller and its CPU-side end
package nvm_pkg;
    // Special function register addresses
    localparam logic [7:0] SFR_FLASH_CONTROL      = 8'h9e;
    localparam logic [7:0] SFR_INDIRECT_PAGE_HIGH = 8'ha1;
    localparam logic [7:0] SFR_POWER_MGMT         = 8'hc4;
    localparam logic [7:0] SFR_FLASH_WRITE_DATA   = 8'hd3;
    localparam logic [7:0] SFR_FLASH_ADDRESS_LOW  = 8'hdb;
    localparam logic [7:0] SFR_FLASH_ADDRESS_HIGH = 8'heb;
    localparam logic [7:0] SFR_EXT_IRQ_ENABLE     = 8'hf9;
    // Field positions
    localparam int CTL_ERASE  = 7;
    localparam int CTL_WRITE  = 6;
    localparam int CTL_ENABLE = 5;
    localparam int CTL_DONE   = 4;
    localparam int IE_FLASH   = 5;
    localparam int PM_AUX     = 0;
    // Geometry
    localparam int FLASH_SIZE = 2048;
    localparam int ADDR_W     = 11;
    localparam int PAGE_BYTES = 64;
    localparam int PAGE_SHIFT = 6;
    localparam int HIGH_BITS  = 3;
    localparam logic [7:0] ERASED_BYTE  = 8'hff;
    localparam logic [7:0] INVALID_READ = 8'hff;
    localparam logic [7:0] ZERO_BYTE    = 8'h00;
    // Timing
    localparam int CLK_HZ        = 25_000_000;
    localparam int ERASE_TIME_US = 5000;
    localparam int WRITE_TIME_US = 50;
    localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
    localparam int ERASE_CYCLES  = ERASE_TIME_US * CYC_PER_US;
    localparam int WRITE_CYCLES  = WRITE_TIME_US * CYC_PER_US;
    localparam int TIMER_W       = 17;
    // Host-side local register addresses and bit positions
    localparam logic [7:0] HOST_MOVE_LOW  = 8'h00;
    localparam logic [7:0] HOST_MOVE_HIGH = 8'h01;
    localparam logic [7:0] HOST_MOVE_DATA = 8'h02;
    localparam logic [7:0] HOST_MOVE_GO   = 8'h03;
    localparam logic [7:0] HOST_MOVE_STAT = 8'h04;
    localparam logic [7:0] HOST_CPU_CTRL  = 8'h05;
    localparam int GO_WRITE    = 1;
    localparam int GO_INDIRECT = 2;
    localparam int CPU_IDLE    = 0;
    localparam int CPU_GIE     = 1;
    localparam int SFR_SPACE   = 7;

    typedef enum logic [1:0] {ROUTE_NONE, ROUTE_FLASH, ROUTE_EXT, ROUTE_AUX} route_t;
endpackage

// ==== logic/nvm_if.sv ====
// Connection between the CPU core and the data flash controller
`timescale 1ns/1ps
interface nvm_if;
    import nvm_pkg::*;
    logic [7:0]  sfr_addr;
    logic [7:0]  sfr_wdata;
    logic        sfr_wr;
    logic        sfr_rd;
    logic [7:0]  sfr_rdata;
    logic        mv_req;
    logic        mv_write;
    logic        mv_indirect;
    logic [15:0] mv_addr;
    logic [7:0]  mv_wdata;
    route_t      mv_route;
    logic [7:0]  mv_rdata;
    logic        cpu_idle;
    logic        global_irq_enable;
    logic        flash_irq;
    logic        wake;

    modport dev (
        input  sfr_addr, sfr_wdata, sfr_wr, sfr_rd, mv_req, mv_write, mv_indirect,
        input  mv_addr, mv_wdata, cpu_idle, global_irq_enable,
        output sfr_rdata, mv_route, mv_rdata, flash_irq, wake
    );
    modport cpu (
        output sfr_addr, sfr_wdata, sfr_wr, sfr_rd, mv_req, mv_write, mv_indirect,
        output mv_addr, mv_wdata, cpu_idle, global_irq_enable,
        input  sfr_rdata, mv_route, mv_rdata, flash_irq, wake
    );
endinterface

// ==== logic/op_timer.sv ====
// Flash operation timer: runs the flash oscillator and counts the operation length
`timescale 1ns/1ps
module op_timer
    import nvm_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               start,
    input  wire logic [TIMER_W-1:0] limit,
    output logic                    osc_en,
    output logic                    done
);
    logic [TIMER_W-1:0] count_r;
    logic               run_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            run_r   <= 1'b0;
            count_r <= '0;
        end else if (start) begin
            run_r   <= 1'b1;
            count_r <= limit - TIMER_W'(1);
        end else if (run_r) begin
            if (count_r == '0) begin
                run_r <= 1'b0;
            end else begin
                count_r <= count_r - TIMER_W'(1);
            end
        end
    end

    // Oscillator enabled only while an operation runs
    assign osc_en = run_r;
    assign done   = run_r && (count_r == '0);
endmodule

// ==== logic/nvm_flash_dev.sv ====
// Data flash controller: move decoding, page erase and byte write sequencing
`timescale 1ns/1ps
module nvm_flash_dev
    import nvm_pkg::*;
#(
    parameter int ERASE_CYC = ERASE_CYCLES
)
(
    input  wire logic              clk,
    input  wire logic              resetn,
    nvm_if.dev                     bus,
    input  wire logic              security_lock,
    input  wire logic              prog_rd,
    input  wire logic [ADDR_W-1:0] prog_addr,
    output logic [7:0]             prog_rdata,
    output logic                   prog_refused,
    output logic                   osc_enable,
    output logic                   busy
);
    typedef enum logic [1:0] {IDLE, ERASING, WRITING} state_t;

    logic [7:0]            mem [FLASH_SIZE];
    state_t                state_r;
    logic                  erase_req_r;
    logic                  write_req_r;
    logic                  enable_r;
    logic                  done_r;
    logic                  irq_en_r;
    logic                  aux_en_r;
    logic [7:0]            page_high_r;
    logic [7:0]            wdata_r;
    logic [7:0]            addr_low_r;
    logic [HIGH_BITS-1:0]  addr_high_r;
    logic                  beyond_r;
    logic [7:0]            sfr_rdata_r;
    logic [7:0]            mv_rdata_r;
    logic [7:0]            prog_rdata_r;
    logic                  prog_refused_r;
    logic [ADDR_W-1:0]     op_addr;
    logic [15:0]           mv_full_addr;
    logic                  mv_in_flash;
    logic                  ctl_wr;
    logic                  start_erase;
    logic                  start_write;
    logic                  timer_start;
    logic [TIMER_W-1:0]    timer_limit;
    logic                  timer_done;

    assign op_addr = {addr_high_r, addr_low_r};
    assign ctl_wr  = bus.sfr_wr && (bus.sfr_addr == SFR_FLASH_CONTROL);
    assign busy    = (state_r != IDLE);

    // Request acceptance
    always_comb begin
        start_erase = 1'b0;
        start_write = 1'b0;
        if (ctl_wr && bus.sfr_wdata[CTL_ENABLE] && !busy && !done_r && !beyond_r) begin
            if (bus.sfr_wdata[CTL_ERASE]) begin
                start_erase = 1'b1;
            end else if (bus.sfr_wdata[CTL_WRITE]) begin
                start_write = 1'b1;
            end
        end
    end

    assign timer_start = start_erase || start_write;
    assign timer_limit = start_erase ? TIMER_W'(ERASE_CYC) : TIMER_W'(WRITE_CYCLES);

    op_timer u_timer (
        .clk    (clk),
        .resetn (resetn),
        .start  (timer_start),
        .limit  (timer_limit),
        .osc_en (osc_enable),
        .done   (timer_done)
    );

    // Operation state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_r <= IDLE;
        end else if (start_erase) begin
            state_r <= ERASING;
        end else if (start_write) begin
            state_r <= WRITING;
        end else if (timer_done) begin
            state_r <= IDLE;
        end
    end

    // Control register: request bits clear in hardware on completion
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            erase_req_r <= 1'b0;
            write_req_r <= 1'b0;
            enable_r    <= 1'b0;
        end else begin
            if (ctl_wr) begin
                enable_r <= bus.sfr_wdata[CTL_ENABLE];
            end
            if (start_erase) begin
                erase_req_r <= 1'b1;
            end else if (start_write) begin
                write_req_r <= 1'b1;
            end else if (timer_done) begin
                erase_req_r <= 1'b0;
                write_req_r <= 1'b0;
            end
        end
    end

    // Done flag: completion wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_r <= 1'b0;
        end else if (timer_done) begin
            done_r <= 1'b1;
        end else if (ctl_wr && !bus.sfr_wdata[CTL_DONE]) begin
            done_r <= 1'b0;
        end
    end

    // Address and data registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            addr_low_r  <= ZERO_BYTE;
            addr_high_r <= '0;
            beyond_r    <= 1'b0;
            wdata_r     <= ZERO_BYTE;
        end else if (bus.sfr_wr) begin
            if (!busy && bus.sfr_addr == SFR_FLASH_ADDRESS_LOW) begin
                addr_low_r <= bus.sfr_wdata;
            end
            if (!busy && bus.sfr_addr == SFR_FLASH_ADDRESS_HIGH) begin
                addr_high_r <= bus.sfr_wdata[HIGH_BITS-1:0];
                beyond_r    <= (bus.sfr_wdata[7:HIGH_BITS] != '0);
            end
            if (state_r != WRITING && bus.sfr_addr == SFR_FLASH_WRITE_DATA) begin
                wdata_r <= bus.sfr_wdata;
            end
        end
    end

    // Other software registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_en_r    <= 1'b0;
            aux_en_r    <= 1'b0;
            page_high_r <= ZERO_BYTE;
        end else if (bus.sfr_wr) begin
            if (bus.sfr_addr == SFR_EXT_IRQ_ENABLE) begin
                irq_en_r <= bus.sfr_wdata[IE_FLASH];
            end
            if (bus.sfr_addr == SFR_POWER_MGMT) begin
                aux_en_r <= bus.sfr_wdata[PM_AUX];
            end
            if (bus.sfr_addr == SFR_INDIRECT_PAGE_HIGH) begin
                page_high_r <= bus.sfr_wdata;
            end
        end
    end

    // Register read data, one cycle after the read strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata_r <= ZERO_BYTE;
        end else if (bus.sfr_rd) begin
            sfr_rdata_r <= ZERO_BYTE;
            unique case (bus.sfr_addr)
                SFR_FLASH_CONTROL: begin
                    sfr_rdata_r[CTL_ERASE]  <= erase_req_r;
                    sfr_rdata_r[CTL_WRITE]  <= write_req_r;
                    sfr_rdata_r[CTL_ENABLE] <= enable_r;
                    sfr_rdata_r[CTL_DONE]   <= done_r;
                end
                SFR_INDIRECT_PAGE_HIGH: sfr_rdata_r <= page_high_r;
                SFR_POWER_MGMT:         sfr_rdata_r[PM_AUX] <= aux_en_r;
                SFR_FLASH_WRITE_DATA:   sfr_rdata_r <= wdata_r;
                SFR_FLASH_ADDRESS_LOW:  sfr_rdata_r <= addr_low_r;
                SFR_FLASH_ADDRESS_HIGH: sfr_rdata_r[HIGH_BITS-1:0] <= addr_high_r;
                SFR_EXT_IRQ_ENABLE:     sfr_rdata_r[IE_FLASH] <= irq_en_r;
                default:                sfr_rdata_r <= ZERO_BYTE;
            endcase
        end
    end

    // Data move decode
    assign mv_full_addr = bus.mv_indirect ? {page_high_r, bus.mv_addr[7:0]}
                                          : bus.mv_addr;
    assign mv_in_flash  = (mv_full_addr < 16'(FLASH_SIZE));

    always_comb begin
        if (!bus.mv_req) begin
            bus.mv_route = ROUTE_NONE;
        end else if (enable_r) begin
            if (!bus.mv_write && mv_in_flash) begin
                bus.mv_route = ROUTE_FLASH;
            end else if (!bus.mv_indirect && !mv_in_flash) begin
                bus.mv_route = ROUTE_EXT;
            end else begin
                bus.mv_route = ROUTE_NONE;
            end
        end else if (aux_en_r) begin
            bus.mv_route = ROUTE_AUX;
        end else begin
            bus.mv_route = ROUTE_EXT;
        end
    end

    // Flash read data for moves; never stalls the core
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mv_rdata_r <= ZERO_BYTE;
        end else if (bus.mv_route == ROUTE_FLASH) begin
            mv_rdata_r <= busy ? INVALID_READ : mem[mv_full_addr[ADDR_W-1:0]];
        end
    end

    // External programmer port guarded by the lock bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prog_rdata_r   <= ZERO_BYTE;
            prog_refused_r <= 1'b0;
        end else if (prog_rd) begin
            prog_refused_r <= !security_lock;
            prog_rdata_r   <= security_lock ? mem[prog_addr] : ZERO_BYTE;
        end
    end

    // Array update at the end of an operation
    always_ff @(posedge clk) begin
        if (timer_done && state_r == ERASING) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                mem[{op_addr[ADDR_W-1:PAGE_SHIFT], PAGE_SHIFT'(i)}] <= ERASED_BYTE;
            end
        end else if (timer_done && state_r == WRITING) begin
            mem[op_addr] <= wdata_r;
        end
    end

    assign bus.sfr_rdata = sfr_rdata_r;
    assign bus.mv_rdata  = mv_rdata_r;
    assign bus.flash_irq = done_r && irq_en_r;
    assign bus.wake      = bus.flash_irq && bus.global_irq_enable && bus.cpu_idle;
    assign prog_rdata    = prog_rdata_r;
    assign prog_refused  = prog_refused_r;
endmodule

// ==== logic/nvm_cpu_host.sv ====
// CPU-side end: forwards register accesses and issues data moves
`timescale 1ns/1ps
module nvm_cpu_host
    import nvm_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    nvm_if.cpu              bus,
    input  wire logic [7:0] sw_addr,
    input  wire logic [7:0] sw_wdata,
    input  wire logic       sw_wr,
    input  wire logic       sw_rd,
    output logic [7:0]      sw_rdata,
    output logic            irq_out,
    output logic            wake_out
);
    logic [15:0] move_addr_r;
    logic [7:0]  move_data_r;
    logic        go_r;
    logic        go_write_r;
    logic        go_ind_r;
    logic        idle_r;
    logic        gie_r;
    route_t      last_route_r;
    logic [7:0]  local_rdata_r;
    logic        sfr_sel_r;
    logic        sfr_hit;

    assign sfr_hit = sw_addr[SFR_SPACE];

    // Register accesses in the upper half go straight to the device
    assign bus.sfr_addr  = sw_addr;
    assign bus.sfr_wdata = sw_wdata;
    assign bus.sfr_wr    = sw_wr && sfr_hit;
    assign bus.sfr_rd    = sw_rd && sfr_hit;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            move_addr_r <= '0;
            move_data_r <= ZERO_BYTE;
            idle_r      <= 1'b0;
            gie_r       <= 1'b0;
        end else if (sw_wr && !sfr_hit) begin
            if (sw_addr == HOST_MOVE_LOW) begin
                move_addr_r[7:0] <= sw_wdata;
            end
            if (sw_addr == HOST_MOVE_HIGH) begin
                move_addr_r[15:8] <= sw_wdata;
            end
            if (sw_addr == HOST_MOVE_DATA) begin
                move_data_r <= sw_wdata;
            end
            if (sw_addr == HOST_CPU_CTRL) begin
                idle_r <= sw_wdata[CPU_IDLE];
                gie_r  <= sw_wdata[CPU_GIE];
            end
        end else if (bus.wake) begin
            idle_r <= 1'b0;
        end
    end

    // One-cycle move request
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            go_r       <= 1'b0;
            go_write_r <= 1'b0;
            go_ind_r   <= 1'b0;
        end else begin
            go_r <= sw_wr && !sfr_hit && (sw_addr == HOST_MOVE_GO);
            if (sw_wr && !sfr_hit && sw_addr == HOST_MOVE_GO) begin
                go_write_r <= sw_wdata[GO_WRITE];
                go_ind_r   <= sw_wdata[GO_INDIRECT];
            end
        end
    end

    assign bus.mv_req            = go_r;
    assign bus.mv_write          = go_write_r;
    assign bus.mv_indirect       = go_ind_r;
    assign bus.mv_addr           = move_addr_r;
    assign bus.mv_wdata          = move_data_r;
    assign bus.cpu_idle          = idle_r;
    assign bus.global_irq_enable = gie_r;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            last_route_r <= ROUTE_NONE;
        end else if (go_r) begin
            last_route_r <= bus.mv_route;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            local_rdata_r <= ZERO_BYTE;
            sfr_sel_r     <= 1'b0;
        end else if (sw_rd) begin
            sfr_sel_r     <= sfr_hit;
            local_rdata_r <= ZERO_BYTE;
            if (sw_addr == HOST_MOVE_STAT) begin
                local_rdata_r <= {6'h00, last_route_r};
            end else if (sw_addr == HOST_MOVE_DATA) begin
                local_rdata_r <= bus.mv_rdata;
            end else if (sw_addr == HOST_CPU_CTRL) begin
                local_rdata_r <= {6'h00, gie_r, idle_r};
            end
        end
    end

    assign sw_rdata = sfr_sel_r ? bus.sfr_rdata : local_rdata_r;
    assign irq_out  = bus.flash_irq;
    assign wake_out = bus.wake;
endmodule

// ==== tb/nvm_flash_props.sv ====
// Concurrent checks on the link between the CPU end and the flash controller
`timescale 1ns/1ps
module nvm_flash_props
    import nvm_pkg::*;
(
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic        mv_req,
    input wire logic        mv_write,
    input wire logic        mv_indirect,
    input wire logic [15:0] mv_addr,
    input wire route_t      mv_route,
    input wire logic        cpu_idle,
    input wire logic        global_irq_enable,
    input wire logic        flash_irq,
    input wire logic        wake
);
    logic        en_r;
    logic        aux_r;
    logic        ie_r;
    logic [7:0]  page_r;
    logic [15:0] ind_addr;

    // Shadow of the register bits that steer moves and the interrupt
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            en_r   <= 1'b0;
            aux_r  <= 1'b0;
            ie_r   <= 1'b0;
            page_r <= 8'h00;
        end else if (sfr_wr) begin
            if (sfr_addr == SFR_FLASH_CONTROL) en_r <= sfr_wdata[CTL_ENABLE];
            if (sfr_addr == SFR_POWER_MGMT) aux_r <= sfr_wdata[PM_AUX];
            if (sfr_addr == SFR_EXT_IRQ_ENABLE) ie_r <= sfr_wdata[IE_FLASH];
            if (sfr_addr == SFR_INDIRECT_PAGE_HIGH) page_r <= sfr_wdata;
        end
    end
    assign ind_addr = {page_r, mv_addr[7:0]};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_route_flash;
        mv_req && en_r && !mv_write && !mv_indirect && mv_addr < 16'h0800
            |-> mv_route == ROUTE_FLASH;
    endproperty
    property p_route_ind;
        mv_req && en_r && !mv_write && mv_indirect && ind_addr < 16'h0800
            |-> mv_route == ROUTE_FLASH;
    endproperty
    property p_route_ext;
        mv_req && en_r && !mv_indirect && mv_addr >= 16'h0800 |-> mv_route == ROUTE_EXT;
    endproperty
    property p_route_none;
        mv_req && en_r && ((mv_write && (mv_indirect || mv_addr < 16'h0800))
            || (mv_indirect && ind_addr >= 16'h0800)) |-> mv_route == ROUTE_NONE;
    endproperty
    property p_route_aux;
        mv_req && !en_r |-> mv_route == (aux_r ? ROUTE_AUX : ROUTE_EXT);
    endproperty
    property p_irq_en;
        !ie_r |-> !flash_irq;
    endproperty
    property p_done_hold;
        flash_irq && !(sfr_wr && (sfr_addr == SFR_FLASH_CONTROL
            || sfr_addr == SFR_EXT_IRQ_ENABLE)) |=> flash_irq;
    endproperty
    property p_addrh_read;
        sfr_rd && sfr_addr == SFR_FLASH_ADDRESS_HIGH |=> sfr_rdata[7:3] == 5'h00;
    endproperty
    property p_wake;
        wake |-> flash_irq && global_irq_enable && cpu_idle;
    endproperty

    a_route_flash: assert property (p_route_flash) else $error("flash read misrouted");
    a_route_ind: assert property (p_route_ind) else $error("indirect read misrouted");
    a_route_ext: assert property (p_route_ext) else $error("external move misrouted");
    a_route_none: assert property (p_route_none) else $error("move not dropped");
    a_route_aux: assert property (p_route_aux) else $error("disabled move misrouted");
    a_irq_en: assert property (p_irq_en) else $error("interrupt while disabled");
    a_done_hold: assert property (p_done_hold) else $error("done dropped alone");
    a_addrh_read: assert property (p_addrh_read) else $error("address high bits set");
    a_wake: assert property (p_wake) else $error("wake without cause");

    c_flash_read: cover property (mv_req && mv_route == ROUTE_FLASH);
    c_irq: cover property ($rose(flash_irq));
    c_wake: cover property (wake);
endmodule

// ==== tb/tb_nvm_data_flash_controller.sv ====
// Self-checking bench for the data flash controller and its CPU-side end
`timescale 1ns/1ps
module tb_nvm_data_flash_controller;
    import nvm_pkg::*;
    localparam int ERASE_SIM = 40;
    logic              clk;
    logic              resetn;
    logic [7:0]        sw_addr;
    logic [7:0]        sw_wdata;
    logic              sw_wr;
    logic              sw_rd;
    logic [7:0]        sw_rdata;
    logic              irq_out;
    logic              wake_out;
    logic              security_lock;
    logic              prog_rd;
    logic [ADDR_W-1:0] prog_addr;
    logic [7:0]        prog_rdata;
    logic              prog_refused;
    logic              osc_enable;
    logic              busy;
    int                err_count;
    int                checks_done;
    int                seed;
    logic [7:0]        rv;
    logic [7:0]        dat;
    logic [15:0]       fa;
    logic              en;
    logic              aux;
    logic              w;
    logic              ind;

    nvm_if nvm_if_inst ();
    nvm_flash_dev #(.ERASE_CYC(ERASE_SIM)) nvm_flash_dev_inst (.clk(clk), .resetn(resetn),
        .bus(nvm_if_inst.dev), .security_lock(security_lock), .prog_rd(prog_rd),
        .prog_addr(prog_addr), .prog_rdata(prog_rdata), .prog_refused(prog_refused),
        .osc_enable(osc_enable), .busy(busy));
    nvm_cpu_host nvm_cpu_host_inst (.clk(clk), .resetn(resetn), .bus(nvm_if_inst.cpu),
        .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .irq_out(irq_out), .wake_out(wake_out));
    nvm_flash_props nvm_flash_props_inst (.clk(clk), .resetn(resetn),
        .sfr_addr(nvm_if_inst.sfr_addr), .sfr_wdata(nvm_if_inst.sfr_wdata),
        .sfr_wr(nvm_if_inst.sfr_wr), .sfr_rd(nvm_if_inst.sfr_rd),
        .sfr_rdata(nvm_if_inst.sfr_rdata), .mv_req(nvm_if_inst.mv_req),
        .mv_write(nvm_if_inst.mv_write), .mv_indirect(nvm_if_inst.mv_indirect),
        .mv_addr(nvm_if_inst.mv_addr), .mv_route(nvm_if_inst.mv_route),
        .cpu_idle(nvm_if_inst.cpu_idle), .global_irq_enable(nvm_if_inst.global_irq_enable),
        .flash_irq(nvm_if_inst.flash_irq), .wake(nvm_if_inst.wake));

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("Checks: %0d, errors: %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sw_addr  <= a;
        sw_wdata <= d;
        sw_wr    <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        sw_addr <= a;
        sw_rd   <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        #1 rv = sw_rdata;
    endtask

    task automatic move(input logic [15:0] a, input logic mw, input logic mi);
        wr(HOST_MOVE_LOW, a[7:0]);
        wr(HOST_MOVE_HIGH, a[15:8]);
        wr(HOST_MOVE_DATA, ~dat);
        wr(HOST_MOVE_GO, {5'h00, mi, mw, 1'b0});
        repeat (2) @(posedge clk);
    endtask

    task automatic flash_op(input logic [10:0] a, input logic [7:0] d, input logic [7:0] ctl);
        wr(SFR_FLASH_ADDRESS_HIGH, {5'h00, a[10:8]});
        wr(SFR_FLASH_ADDRESS_LOW, a[7:0]);
        wr(SFR_FLASH_WRITE_DATA, d);
        wr(SFR_FLASH_CONTROL, ctl);
    endtask

    task automatic wait_done(input int n);
        int k;
        k = 0;
        repeat (n * 3 / 4) @(posedge clk);
        rd(SFR_FLASH_CONTROL);
        check({busy, osc_enable, rv[CTL_DONE]}, 3'b110);
        while (rv[CTL_DONE] !== 1'b1 && k < n) begin
            rd(SFR_FLASH_CONTROL);
            k++;
        end
        check(rv[7:4], 4'h3);
        check({busy, osc_enable, irq_out}, 3'b001);
    endtask

    task automatic prog(input logic lock, input logic [7:0] exp);
        @(posedge clk);
        security_lock <= lock;
        prog_addr <= fa[10:0];
        prog_rd   <= 1'b1;
        @(posedge clk);
        prog_rd <= 1'b0;
        #1 check({prog_refused, prog_rdata}, {~lock, exp});
    endtask

    function automatic route_t exp_route(input logic e, input logic x, input logic [7:0] pg,
                                         input logic [15:0] a, input logic mw, input logic mi);
        logic [15:0] ea;
        ea = mi ? {pg, a[7:0]} : a;
        if (!e) return x ? ROUTE_AUX : ROUTE_EXT;
        if (ea < 16'(FLASH_SIZE)) return mw ? ROUTE_NONE : ROUTE_FLASH;
        return mi ? ROUTE_NONE : ROUTE_EXT;
    endfunction

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end

    initial begin
        seed = 84216;
        err_count = 0;
        checks_done = 0;
        resetn = 1'b0;
        {sw_addr, sw_wdata, sw_wr, sw_rd, prog_rd, prog_addr, dat} = '0;
        security_lock = 1'b1;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        rd(SFR_FLASH_ADDRESS_HIGH);
        check(rv, 8'h00);
        wr(SFR_EXT_IRQ_ENABLE, 8'h20);
        wr(HOST_CPU_CTRL, 8'h03);
        // Erase page 31 from an address in the middle of the page
        flash_op(11'h7f0, 8'h00, 8'ha0);
        wait_done(ERASE_SIM);
        rd(HOST_CPU_CTRL);
        check(rv[CPU_IDLE], 1'b0);
        wr(SFR_FLASH_CONTROL, 8'h20);
        rd(SFR_FLASH_CONTROL);
        check({irq_out, rv[CTL_DONE]}, 2'b00);
        fa = 16'h07c0 + 16'($unsigned($random(seed)) % 64);
        move(fa, 1'b0, 1'b0);
        rd(HOST_MOVE_DATA);
        check(rv, ERASED_BYTE);
        // Byte write, with conflicting requests while it runs
        dat = 8'($random(seed));
        flash_op(fa[10:0], dat, 8'h60);
        wr(SFR_FLASH_CONTROL, 8'ha0);
        wr(SFR_FLASH_ADDRESS_HIGH, 8'h03);
        wr(SFR_FLASH_WRITE_DATA, ~dat);
        move(fa ^ 16'h0040, 1'b0, 1'b0);
        rd(HOST_MOVE_DATA);
        check(rv, INVALID_READ);
        rd(SFR_FLASH_ADDRESS_HIGH);
        check(rv, 8'h07);
        wait_done(WRITE_CYCLES);
        move(fa, 1'b0, 1'b0);
        rd(HOST_MOVE_DATA);
        check(rv, dat);
        wr(SFR_INDIRECT_PAGE_HIGH, 8'h07);
        move({8'h00, fa[7:0]}, 1'b0, 1'b1);
        rd(HOST_MOVE_DATA);
        check(rv, dat);
        move(fa, 1'b1, 1'b0);
        move(fa, 1'b0, 1'b0);
        rd(HOST_MOVE_DATA);
        check(rv, dat);
        prog(1'b1, dat);
        prog(1'b0, ZERO_BYTE);
        // Requests while done is still set, then beyond the flash
        flash_op(fa[10:0], 8'h11, 8'h70);
        rd(SFR_FLASH_CONTROL);
        check({busy, rv[7:4]}, 5'h03);
        wr(SFR_FLASH_CONTROL, 8'h20);
        wr(SFR_FLASH_ADDRESS_HIGH, 8'h10);
        wr(SFR_FLASH_CONTROL, 8'h60);
        rd(SFR_FLASH_CONTROL);
        check({busy, rv[7:4]}, 5'h02);
        rd(8'h06);
        check(rv, 8'h00);
        // Routing of moves over enable, aux and address corners
        for (int i = 0; i < 16; i++) begin
            en = i[0];
            aux = i[1];
            fa = i[3] ? 16'($random(seed)) : 16'h07ff + 16'(i[2]);
            w = 1'($random(seed));
            ind = 1'($random(seed));
            dat = {5'h00, 3'($random(seed))} + 8'(i[2]);
            wr(SFR_FLASH_CONTROL, {2'b00, en, 5'h00});
            wr(SFR_POWER_MGMT, {7'h00, aux});
            wr(SFR_INDIRECT_PAGE_HIGH, dat);
            move(fa, w, ind);
            rd(HOST_MOVE_STAT);
            check(rv[1:0], exp_route(en, aux, dat, fa, w, ind));
        end
        report_and_stop();
    end
endmodule
